// file: rtl/iac_ctrl_regs.sv
/*
 * Control and own-address registers of a two-wire bus controller,
 * reached over AHB-Lite, with input spike filters, address matching
 * and master launch control.
 * Assumes one slave on the bus, word accesses only, and a protocol
 * engine on core_clk that consumes the iac_eng_out_s commands.
 */
// Added by the designer: the AHB-Lite interface to the registers.
// How it works
// - General call address acked only when enabled
// - Wakeup enable settable only with zero filter
// - Stretch disable off; changed only while disabled
// - Slave byte control enables slave byte counting
// - DMA requests gated by their enable bits
// - Filter drops spikes up to N cycles
// - Seven enable bits gate interrupt sources
// - Peripheral off releases lines, resets state
// - Auto end sends stop after count
// - Byte count with reload; slave needs byte control
// - NACK request cleared by nack, stop, match
// - Stop request cleared on stop or disable
// - Start cleared after address, loss, clear
// - Start waits for idle bus, blocked by reload
// - Ten-bit read restart unless header only
// - Target address bits by addressing mode
// - Own address one match in both modes
// - Own address fields locked while enabled
// - Mask code hides low own-two bits
// - Own address two match on unmasked bits
// - Back-to-back writes stall until settled
`include "iac_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module iac_ctrl_regs
	import iac_pkg::*;
(
	input  wire logic         core_clk,  // 100 MHz clock
	input  wire logic         resetn,    // Async reset, active low
	input  wire logic         hsel,      // Slave select
	input  wire logic [31:0]  haddr,     // Byte address
	input  wire logic [1:0]   htrans,    // Transfer type
	input  wire logic         hwrite,    // Write when high
	input  wire logic [2:0]   hsize,     // Word only
	input  wire logic [31:0]  hwdata,    // Write data
	input  wire logic         hready,    // Bus ready
	output logic              hreadyout, // Slave ready
	output logic              hresp,     // Always OKAY
	output logic [31:0]       hrdata,    // Read data
	input  wire logic         sclIn,     // Clock line level
	output logic              sclOut,    // Clock line drive value
	output logic              sclOe,     // Clock line pulled low
	input  wire logic         sdaIn,     // Data line level
	output logic              sdaOut,    // Data line drive value
	output logic              sdaOe,     // Data line pulled low
	input  wire iac_eng_in_s  eng,       // Engine events
	output iac_eng_out_s      engOut     // Engine commands
);
	// ==========================================================
	// State record
	typedef struct packed {
		logic [31:0]  ctrlOne;
		logic [31:0]  ctrlTwo;
		logic [31:0]  ownOne;
		logic [31:0]  ownTwo;
		logic         startIssued;
		logic         autoStop;
		logic         wrPend;
		logic [7:0]   wrAddr;
		logic [3:0]   busy;
		logic         hready;
		logic [31:0]  rdata;
		logic [1:0]   sclSync;
		logic [1:0]   sdaSync;
		logic [3:0]   sclCnt;
		logic [3:0]   sdaCnt;
		iac_eng_out_s out;
	} iac_state_s;

	localparam logic [3:0] WR_SYNC = 4'(`IAC_WR_SYNC_CYC);

	logic [1:0]  rstSync_ff;
	logic        rstn;
	iac_state_s  st_ff;
	iac_state_s  nxt_st;

	// ==========================================================
	// Spike filter: a new level is taken after len+1 steady cycles
	function automatic logic [4:0] filterStep(
		input logic       raw,
		input logic       cur,
		input logic [3:0] cnt,
		input logic [3:0] len
	);
		logic [4:0] res;
		res = {cur, 4'h0};
		if (raw != cur) begin
			if (cnt >= len) begin
				res = {raw, 4'h0};
			end else begin
				res = {cur, 4'(cnt + 4'h1)};
			end
		end
		return res;
	endfunction : filterStep

	// ==========================================================
	// Address decision for a received slave address
	function automatic logic addrAckCalc(
		input logic [9:0]  a,
		input logic        ten,
		input logic [31:0] c1,
		input logic [31:0] o1,
		input logic [31:0] o2
	);
		logic [6:0] keep;
		logic       gc;
		logic       hit1;
		logic       hit2;
		logic       rsv;
		keep = 7'h7f << o2[`IAC_OWN2_MSK_HI:`IAC_OWN2_MSK_LO];
		gc   = c1[`IAC_C1_GCALL] && !ten && (a[7:1] == 7'h00);
		if (o1[`IAC_OWN1_TEN]) begin
			hit1 = ten && (a == o1[9:0]);
		end else begin
			hit1 = !ten && (a[7:1] == o1[7:1]);
		end
		hit1 = hit1 && o1[`IAC_OWN_EN];
		rsv  = (a[7:4] == 4'h0) || (a[7:4] == 4'hf);
		hit2 = o2[`IAC_OWN_EN] && !ten
			&& ((a[7:1] & keep) == (o2[7:1] & keep))
			&& !((keep == 7'h00) && rsv);
		return gc || hit1 || hit2;
	endfunction : addrAckCalc

	// ==========================================================
	// Reset release through two flops
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rstSync_ff <= 2'b00;
		end else begin
			rstSync_ff <= {rstSync_ff[0], 1'b1};
		end
	end
	assign rstn = rstSync_ff[1];

	// ==========================================================
	// Next-state logic
	always_comb begin
		logic       isOn;
		logic       take;
		logic [3:0] fltLen;
		logic [31:0] w;
		logic [31:0] c2;
		nxt_st = st_ff;
		isOn   = st_ff.ctrlOne[`IAC_C1_ON];
		fltLen = st_ff.ctrlOne[`IAC_C1_FLT_HI:`IAC_C1_FLT_LO];
		take   = hsel && hready && htrans[1];
		w      = `IAC_REG_RESET;
		c2     = st_ff.ctrlTwo;
		nxt_st.out.startGo      = 1'b0;
		nxt_st.out.addrAckValid = 1'b0;
		nxt_st.out.addrAck      = 1'b0;

		// Pin synchronisers, second flop feeds the filters
		nxt_st.sclSync = {st_ff.sclSync[0], sclIn};
		nxt_st.sdaSync = {st_ff.sdaSync[0], sdaIn};
		{nxt_st.out.sclFilt, nxt_st.sclCnt} = filterStep(
			st_ff.sclSync[1], st_ff.out.sclFilt, st_ff.sclCnt, fltLen);
		{nxt_st.out.sdaFilt, nxt_st.sdaCnt} = filterStep(
			st_ff.sdaSync[1], st_ff.out.sdaFilt, st_ff.sdaCnt, fltLen);

		// Hardware clears of the request bits
		if (eng.nackSent || eng.stopDetected || eng.addrMatched) begin
			c2[`IAC_C2_NACK] = 1'b0;
		end
		if (eng.stopDetected) begin
			c2[`IAC_C2_STOP] = 1'b0;
		end
		if (eng.startSent || eng.arbLost) begin
			c2[`IAC_C2_START] = 1'b0;
		end

		// Write data phase, held off while a previous write settles
		if (st_ff.wrPend && (st_ff.busy == 4'h0)) begin
			nxt_st.wrPend = 1'b0;
			nxt_st.busy   = WR_SYNC;
			case (st_ff.wrAddr)
				`IAC_OFF_CTRL1: begin
					w = hwdata & `IAC_C1_WMASK;
					if (isOn) begin
						w[`IAC_C1_NOSTR] = st_ff.ctrlOne[`IAC_C1_NOSTR];
						w[`IAC_C1_FLT_HI:`IAC_C1_FLT_LO] = fltLen;
					end
					if (w[`IAC_C1_FLT_HI:`IAC_C1_FLT_LO] != 4'h0) begin
						w[`IAC_C1_WUP] = st_ff.ctrlOne[`IAC_C1_WUP];
					end
					nxt_st.ctrlOne = w;
				end
				`IAC_OFF_CTRL2: begin
					// Request bits only set by software, so a set wins
					c2 = (hwdata & `IAC_C2_WMASK & ~`IAC_C2_SETMASK)
						| ((c2 | hwdata) & `IAC_C2_SETMASK);
				end
				`IAC_OFF_OWN1: begin
					if (st_ff.ownOne[`IAC_OWN_EN]) begin
						nxt_st.ownOne[`IAC_OWN_EN] = hwdata[`IAC_OWN_EN];
					end else begin
						nxt_st.ownOne = hwdata & `IAC_OWN1_WMASK;
					end
				end
				`IAC_OFF_OWN2: begin
					if (st_ff.ownTwo[`IAC_OWN_EN]) begin
						nxt_st.ownTwo[`IAC_OWN_EN] = hwdata[`IAC_OWN_EN];
					end else begin
						nxt_st.ownTwo = hwdata & `IAC_OWN2_WMASK;
					end
				end
				`IAC_OFF_CLEAR: begin
					if (hwdata[`IAC_CLR_ADDR]) begin
						c2[`IAC_C2_START] = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end else if (st_ff.busy != 4'h0) begin
			nxt_st.busy = st_ff.busy - 4'h1;
		end

		// Disabled peripheral: requests and filters back to idle
		if (!nxt_st.ctrlOne[`IAC_C1_ON]) begin
			c2[`IAC_C2_NACK]   = 1'b0;
			c2[`IAC_C2_STOP]   = 1'b0;
			c2[`IAC_C2_START]  = 1'b0;
			nxt_st.out.sclFilt = 1'b1;
			nxt_st.out.sdaFilt = 1'b1;
			nxt_st.sclCnt      = 4'h0;
			nxt_st.sdaCnt      = 4'h0;
		end
		nxt_st.ctrlTwo = c2;

		// Address phase: reads answer from the current state
		if (take) begin
			if (hwrite) begin
				nxt_st.wrPend = 1'b1;
				nxt_st.wrAddr = haddr[7:0];
			end else begin
				case (haddr[7:0])
					`IAC_OFF_CTRL1:  nxt_st.rdata = st_ff.ctrlOne;
					`IAC_OFF_CTRL2:  nxt_st.rdata = st_ff.ctrlTwo;
					`IAC_OFF_OWN1:   nxt_st.rdata = st_ff.ownOne;
					`IAC_OFF_OWN2:   nxt_st.rdata = st_ff.ownTwo;
					`IAC_OFF_STATUS: nxt_st.rdata = {16'h0000, eng.busBusy,
						5'h00, st_ff.out.sdaFilt, st_ff.out.sclFilt,
						1'b0, eng.flags};
					default:         nxt_st.rdata = 32'h00000000;
				endcase
			end
		end
		nxt_st.hready = !(nxt_st.wrPend && (nxt_st.busy != 4'h0));

		// Master launch: once per request, idle bus, no reload
		if (!st_ff.ctrlTwo[`IAC_C2_START]) begin
			nxt_st.startIssued = 1'b0;
		end else if (isOn && !st_ff.startIssued
			&& !st_ff.ctrlTwo[`IAC_C2_RELOAD] && !eng.busBusy) begin
			nxt_st.out.startGo = 1'b1;
			nxt_st.startIssued = 1'b1;
		end

		// Automatic stop after the count, master only, no reload
		if (!isOn || eng.stopDetected) begin
			nxt_st.autoStop = 1'b0;
		end else if (eng.byteCountDone && eng.isMaster
			&& st_ff.ctrlTwo[`IAC_C2_AUTO]
			&& !st_ff.ctrlTwo[`IAC_C2_RELOAD]) begin
			nxt_st.autoStop = 1'b1;
		end
		nxt_st.out.stopReq = isOn && (st_ff.ctrlTwo[`IAC_C2_STOP]
			|| st_ff.autoStop);

		// Launch fields; ten-bit reads restart unless header only
		nxt_st.out.tenMode    = st_ff.ctrlTwo[`IAC_C2_TEN];
		nxt_st.out.readDir    = st_ff.ctrlTwo[`IAC_C2_DIR];
		nxt_st.out.target     = st_ff.ctrlTwo[9:0];
		nxt_st.out.tenRestart = st_ff.ctrlTwo[`IAC_C2_TEN]
			&& st_ff.ctrlTwo[`IAC_C2_DIR]
			&& !st_ff.ctrlTwo[`IAC_C2_HEAD];
		nxt_st.out.byteCount  =
			st_ff.ctrlTwo[`IAC_C2_NB_HI:`IAC_C2_NB_LO];
		nxt_st.out.reload     = st_ff.ctrlTwo[`IAC_C2_RELOAD];
		nxt_st.out.countActive = eng.isMaster
			|| st_ff.ctrlOne[`IAC_C1_SBYTE];
		nxt_st.out.nackNext   = isOn && !eng.isMaster
			&& st_ff.ctrlTwo[`IAC_C2_NACK];
		nxt_st.out.stretchEn  = !st_ff.ctrlOne[`IAC_C1_NOSTR];
		nxt_st.out.wakeEn     = st_ff.ctrlOne[`IAC_C1_WUP];

		// Address match decision, one cycle after the address
		if (isOn && eng.rxAddrValid) begin
			nxt_st.out.addrAckValid = 1'b1;
			nxt_st.out.addrAck = addrAckCalc(eng.rxAddr, eng.rxAddrTen,
				st_ff.ctrlOne, st_ff.ownOne, st_ff.ownTwo);
		end

		// DMA, interrupt and line drive, all silenced when disabled
		nxt_st.out.dmaRx = isOn && st_ff.ctrlOne[`IAC_C1_RXDMA]
			&& eng.rxReady;
		nxt_st.out.dmaTx = isOn && st_ff.ctrlOne[`IAC_C1_TXDMA]
			&& eng.txReady;
		nxt_st.out.irq = isOn && |(eng.flags
			& st_ff.ctrlOne[`IAC_C1_IE_HI:`IAC_C1_IE_LO]);
		nxt_st.out.sclOe = isOn && eng.sclPull;
		nxt_st.out.sdaOe = isOn && eng.sdaPull;
	end

	// ==========================================================
	// State register
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			st_ff <= '0;
			st_ff.hready <= 1'b1;
			st_ff.out.sclFilt <= 1'b1;
			st_ff.out.sdaFilt <= 1'b1;
			st_ff.out.stretchEn <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Open-drain: the drive value is always low, the enable pulls
	assign hreadyout = st_ff.hready;
	assign hresp     = st_ff.wrPend & 1'b0;
	assign hrdata    = st_ff.rdata;
	assign sclOut    = st_ff.out.sclOe & 1'b0;
	assign sdaOut    = st_ff.out.sdaOe & 1'b0;
	assign sclOe     = st_ff.out.sclOe;
	assign sdaOe     = st_ff.out.sdaOe;
	assign engOut    = st_ff.out;

	// ==========================================================
	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	logic [3:0] stallCnt_ff;
	logic       c2Write;
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			stallCnt_ff <= 4'h0;
		end else if (!st_ff.hready) begin
			stallCnt_ff <= stallCnt_ff + 4'h1;
		end else begin
			stallCnt_ff <= 4'h0;
		end
	end
	assign c2Write = st_ff.wrPend && (st_ff.wrAddr == `IAC_OFF_CTRL2);

	property p_gc_nack;
		eng.rxAddrValid && !eng.rxAddrTen && (eng.rxAddr == 10'h000)
		&& !st_ff.ctrlOne[`IAC_C1_GCALL] && !st_ff.ownOne[`IAC_OWN_EN]
		&& !st_ff.ownTwo[`IAC_OWN_EN] |=> !st_ff.out.addrAck;
	endproperty
	a_gc_nack: assert property (p_gc_nack)
		else $error("general call acked while disabled");
	property p_wup;
		$rose(st_ff.ctrlOne[`IAC_C1_WUP])
		|-> st_ff.ctrlOne[`IAC_C1_FLT_HI:`IAC_C1_FLT_LO] == 4'h0;
	endproperty
	a_wup: assert property (p_wup)
		else $error("wakeup set with filter active");
	property p_nostr_lock;
		$past(st_ff.ctrlOne[`IAC_C1_ON]) |-> $stable(st_ff.ctrlOne[`IAC_C1_NOSTR]);
	endproperty
	a_nostr_lock: assert property (p_nostr_lock)
		else $error("stretch disable changed while enabled");
	property p_flt_lock;
		$past(st_ff.ctrlOne[`IAC_C1_ON])
		|-> $stable(st_ff.ctrlOne[`IAC_C1_FLT_HI:`IAC_C1_FLT_LO]);
	endproperty
	a_flt_lock: assert property (p_flt_lock)
		else $error("filter length changed while enabled");
	property p_dma;
		st_ff.out.dmaRx |-> $past(st_ff.ctrlOne[`IAC_C1_RXDMA]);
	endproperty
	a_dma: assert property (p_dma)
		else $error("receive dma request without enable");
	property p_irq;
		st_ff.out.irq |-> $past(|(eng.flags
			& st_ff.ctrlOne[`IAC_C1_IE_HI:`IAC_C1_IE_LO]));
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt without enabled flag");
	property p_off;
		!st_ff.ctrlOne[`IAC_C1_ON] |=> !st_ff.out.sclOe && !st_ff.out.sdaOe
		&& !st_ff.out.startGo;
	endproperty
	a_off: assert property (p_off)
		else $error("activity while disabled");
	property p_start_clr;
		eng.startSent && !c2Write |=> !st_ff.ctrlTwo[`IAC_C2_START];
	endproperty
	a_start_clr: assert property (p_start_clr)
		else $error("start request not cleared");
	property p_stop_clr;
		eng.stopDetected && !c2Write |=> !st_ff.ctrlTwo[`IAC_C2_STOP];
	endproperty
	a_stop_clr: assert property (p_stop_clr)
		else $error("stop request not cleared");
	property p_launch;
		st_ff.out.startGo |-> $past(!st_ff.ctrlTwo[`IAC_C2_RELOAD]
			&& !eng.busBusy);
	endproperty
	a_launch: assert property (p_launch)
		else $error("start launched on busy bus or reload");
	property p_stall;
		stallCnt_ff <= WR_SYNC;
	endproperty
	a_stall: assert property (p_stall)
		else $error("write stall too long");

	c_launch: cover property (st_ff.out.startGo);
	c_stall: cover property (!st_ff.hready ##1 st_ff.hready);
	c_ack: cover property (st_ff.out.addrAckValid && st_ff.out.addrAck);
	c_autostop: cover property (st_ff.autoStop);
endmodule : iac_ctrl_regs

`default_nettype wire

// file: rtl/iac_consts.svh
/*
 * Register map, field positions and timing figures of the two-wire
 * controller configuration block.
 * Assumes a single 100 MHz clock that serves as bus and kernel clock.
 */
`ifndef IAC_CONSTS_SVH
`define IAC_CONSTS_SVH
// ==========================================================
// Register byte offsets
`define IAC_OFF_CTRL1    8'h00
`define IAC_OFF_CTRL2    8'h04
`define IAC_OFF_OWN1     8'h08
`define IAC_OFF_OWN2     8'h0c
`define IAC_OFF_STATUS   8'h18
`define IAC_OFF_CLEAR    8'h1c
// ==========================================================
// Writable bits and reset value
`define IAC_C1_WMASK     32'h000fcfff
`define IAC_C2_WMASK     32'h03ffffff
`define IAC_C2_SETMASK   32'h0000e000
`define IAC_OWN1_WMASK   32'h000087ff
`define IAC_OWN2_WMASK   32'h000087fe
`define IAC_REG_RESET    32'h00000000
// ==========================================================
// Field positions, control_one
`define IAC_C1_GCALL     19
`define IAC_C1_WUP       18
`define IAC_C1_NOSTR     17
`define IAC_C1_SBYTE     16
`define IAC_C1_RXDMA     15
`define IAC_C1_TXDMA     14
`define IAC_C1_FLT_HI    11
`define IAC_C1_FLT_LO    8
`define IAC_C1_IE_HI     7
`define IAC_C1_IE_LO     1
`define IAC_C1_ON        0
// Field positions, control_two
`define IAC_C2_AUTO      25
`define IAC_C2_RELOAD    24
`define IAC_C2_NB_HI     23
`define IAC_C2_NB_LO     16
`define IAC_C2_NACK      15
`define IAC_C2_STOP      14
`define IAC_C2_START     13
`define IAC_C2_HEAD      12
`define IAC_C2_TEN       11
`define IAC_C2_DIR       10
// Field positions, own address registers and clear register
`define IAC_OWN_EN       15
`define IAC_OWN1_TEN     10
`define IAC_OWN2_MSK_HI  10
`define IAC_OWN2_MSK_LO  8
`define IAC_CLR_ADDR     3
// ==========================================================
// Write completion latency: 3 bus plus 4 kernel clock periods
`define IAC_BUS_CLK_NS   10
`define IAC_KER_CLK_NS   10
`define IAC_WR_SYNC_NS   (3 * `IAC_BUS_CLK_NS + 4 * `IAC_KER_CLK_NS)
`define IAC_WR_SYNC_CYC  (`IAC_WR_SYNC_NS / `IAC_BUS_CLK_NS)
`endif

// file: rtl/iac_pkg.sv
/*
 * Types shared by the configuration block and its neighbours.
 * Assumes the protocol engine runs on the same clock as this block.
 */
package iac_pkg;
	// ==========================================================
	// Events and levels from the protocol engine
	typedef struct packed {
		logic       startSent;
		logic       arbLost;
		logic       stopDetected;
		logic       nackSent;
		logic       addrMatched;
		logic       byteCountDone;
		logic       busBusy;
		logic       isMaster;
		logic       rxAddrValid;
		logic       rxAddrTen;
		logic [9:0] rxAddr;
		logic       rxReady;
		logic       txReady;
		logic       sclPull;
		logic       sdaPull;
		logic [6:0] flags;
	} iac_eng_in_s;
	// ==========================================================
	// Commands and configuration towards the protocol engine
	typedef struct packed {
		logic       startGo;
		logic       stopReq;
		logic       addrAckValid;
		logic       addrAck;
		logic       tenRestart;
		logic       tenMode;
		logic       readDir;
		logic [9:0] target;
		logic [7:0] byteCount;
		logic       reload;
		logic       countActive;
		logic       stretchEn;
		logic       nackNext;
		logic       wakeEn;
		logic       sclFilt;
		logic       sdaFilt;
		logic       dmaRx;
		logic       dmaTx;
		logic       irq;
		logic       sclOe;
		logic       sdaOe;
	} iac_eng_out_s;
endpackage : iac_pkg

// file: sim/iac_far_side.sv
/*
 * Far-side model: other parties on the two-wire bus and the engine
 * events they cause. Assumes the bench steers frames and levels.
 */
`timescale 1ns/1ps
`default_nettype none

module iac_far_side
	import iac_pkg::*;
(
	input  wire logic         core_clk, // Clock
	input  wire logic         resetn,   // Reset, active low
	input  wire iac_eng_out_s engOut,   // Engine commands
	input  wire logic         sclOe,    // Clock line pulled low
	input  wire logic         sdaOe,    // Data line pulled low
	input  wire logic         slow,     // Late start answer
	input  wire logic         busy,     // Another master on the bus
	input  wire logic         addrGo,   // Address frame seen
	input  wire logic         addrTen,  // Ten-bit frame
	input  wire logic [9:0]   addr,     // Frame address
	input  wire logic [6:0]   flags,    // Status levels
	input  wire logic         rdy,      // Data ready levels
	output iac_eng_in_s       eng,      // Engine events
	output logic              sclIn,    // Clock line level
	output logic              sdaIn     // Data line level
);
	logic [3:0] waitCnt;

	// ==========================================================
	// Lines have pull-ups, so a released line reads high
	assign sclIn = !sclOe;
	assign sdaIn = !sdaOe;

	// Start and address go out after 1 or 6 cycles
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			waitCnt <= 4'h0;
		else if (engOut.startGo)
			waitCnt <= slow ? 4'h6 : 4'h1;
		else if (waitCnt != 4'h0)
			waitCnt <= waitCnt - 4'h1;
	end

	// Busy level held while another master owns the bus
	always_comb begin
		eng             = '0;
		eng.startSent   = (waitCnt == 4'h1);
		// A zero-byte transfer is complete once the address is out
		eng.byteCountDone = (waitCnt == 4'h1);
		eng.busBusy     = busy;
		eng.isMaster    = (waitCnt != 4'h0);
		eng.rxAddrValid = addrGo;
		eng.rxAddrTen   = addrTen;
		eng.rxAddr      = addr;
		eng.rxReady     = rdy;
		eng.txReady     = rdy;
		eng.sclPull     = busy;
		eng.sdaPull     = busy;
		eng.flags       = flags;
	end
endmodule : iac_far_side
`default_nettype wire

// file: sim/iac_ctrl_regs_bench.sv
/*
 * Self-checking bench of the configuration block.
 * Assumes one AHB-Lite slave and the far-side model beside it.
 */
`include "iac_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module iac_ctrl_regs_bench
	import iac_pkg::*;
;
	localparam logic [7:0] C1 = `IAC_OFF_CTRL1;
	localparam logic [7:0] C2 = `IAC_OFF_CTRL2;
	localparam logic [7:0] O1 = `IAC_OFF_OWN1;
	localparam logic [7:0] O2 = `IAC_OFF_OWN2;
	logic core_clk = 1'b0;
	logic resetn = 1'b0, hsel, hwrite, dphRd = 1'b0;
	logic [31:0] haddr, hwdata, cfg, v, d;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic slow, busy, addrGo, addrTen, rdy, e;
	logic [9:0] addr;
	logic [6:0] flags, p;
	wire logic hreadyout, hresp, sclOut, sdaOut, sclOe, sdaOe;
	wire logic sclIn, sdaIn;
	wire logic [31:0] hrdata;
	iac_eng_in_s eng;
	iac_eng_out_s engOut;
	int miscompares = 0, compares = 0, stallRun = 0, stallMax = 0;
	int goCnt = 0;
	logic [31:0] rdQ[$];
	logic ackQ[$];

	// ==========================================================
	// Clock, design and far side
	always #5 core_clk = !core_clk;

	iac_ctrl_regs dut (.core_clk(core_clk), .resetn(resetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.sclIn(sclIn), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaIn),
		.sdaOut(sdaOut), .sdaOe(sdaOe), .eng(eng), .engOut(engOut));

	iac_far_side far (.core_clk(core_clk), .resetn(resetn),
		.engOut(engOut), .sclOe(sclOe), .sdaOe(sdaOe), .slow(slow),
		.busy(busy), .addrGo(addrGo), .addrTen(addrTen), .addr(addr),
		.flags(flags), .rdy(rdy), .eng(eng), .sclIn(sclIn),
		.sdaIn(sdaIn));

	// ==========================================================
	// Compare tasks and the single verdict
	task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk32

	task automatic chk1(input logic got, input logic exp);
		chk32({31'h0, got}, {31'h0, exp});
	endtask : chk1

	task stop_test;
		$display("Compares %0d, miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : stop_test

	// ==========================================================
	// Bus master: hold each phase until hready is sampled high
	task automatic bus(input logic [7:0] a, input logic w,
		input logic [31:0] wd);
		htrans <= 2'h2;
		haddr  <= {24'h0, a};
		hwrite <= w;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		bus(a, 1'b1, wd);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		rdQ.push_back(exp);
		bus(a, 1'b0, 32'h0);
	endtask : rd

	// Address frame from another master; ack expected a cycle later
	task automatic probe(input logic t, input logic [9:0] a,
		input logic exp);
		ackQ.push_back(exp);
		addrTen <= t;
		addr    <= a;
		addrGo  <= 1'b1;
		@(posedge core_clk);
		addrGo  <= 1'b0;
		repeat (3) @(posedge core_clk);
	endtask : probe

	// ==========================================================
	// Watcher: oldest note is compared when a result appears
	always @(posedge core_clk) begin
		if (dphRd && hreadyout === 1'b1)
			chk32(hrdata, rdQ.pop_front());
		if (engOut.addrAckValid === 1'b1)
			chk1(engOut.addrAck, ackQ.pop_front());
		if (engOut.startGo === 1'b1)
			goCnt++;
		stallRun = (hreadyout === 1'b0) ? stallRun + 1 : 0;
		if (stallRun > stallMax)
			stallMax = stallRun;
		if (hreadyout === 1'b1)
			dphRd = hsel && htrans[1] && !hwrite;
	end

	// Watchdog: far beyond the several hundred cycles the tests need
	initial begin
		#400000;
		miscompares++;
		stop_test();
	end

	// ==========================================================
	// Main sequence
	initial begin
		hsel = 1'b1; haddr = '0; htrans = '0; hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = '0; slow = 1'b0; busy = 1'b0; addrGo = 1'b0;
		addrTen = 1'b0; addr = '0; flags = '0; rdy = 1'b0;
		void'($urandom(48));
		repeat (20) @(posedge core_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge core_clk);
		chk1(engOut.stretchEn, 1'b1);
		for (int i = 0; i < 5; i++)
			rd(8'(4 * i), 32'h0);
		wr(C1, 32'h00040100);
		rd(C1, 32'h00000100);
		wr(C1, 32'h00040000);
		rd(C1, 32'h00040000);
		chk1(engOut.wakeEn, 1'b1);
		wr(C2, 32'h0);
		wr(C2, 32'h0);
		chk1(stallMax >= 1 && stallMax <= 6, 1'b1);
		// Zero filter length lets the wakeup bit be cleared again
		wr(C1, 32'h0);
		cfg = $urandom & 32'h000bcffe;
		wr(C1, cfg);
		rd(C1, cfg);
		chk1(engOut.stretchEn, !cfg[17]);
		chk1(engOut.countActive, cfg[16]);
		chk1(engOut.wakeEn, 1'b0);
		wr(C1, cfg | 32'h1);
		wr(C1, (cfg ^ 32'h00020f00) | 32'h1);
		rd(C1, cfg | 32'h1);
		rdy <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			d = $urandom;
			flags <= d[6:0];
			repeat (3) @(posedge core_clk);
			chk1(engOut.irq, |(d[6:0] & cfg[7:1]));
			chk1(engOut.dmaRx, cfg[15]);
			chk1(engOut.dmaTx, cfg[14]);
		end
		flags <= '0;
		rdy <= 1'b0;
		busy <= 1'b1;
		repeat (3) @(posedge core_clk);
		chk1(sclOe, 1'b1);
		chk1(sclOut | sdaOut | hresp, 1'b0);
		repeat (20) @(posedge core_clk);
		chk1(engOut.sclFilt, 1'b0);
		wr(C1, cfg);
		repeat (2) @(posedge core_clk);
		chk1(sdaOe, 1'b0);
		busy <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			d = ($urandom & 32'h03ff03ff) | (32'(i) << 10);
			wr(C2, d);
			repeat (2) @(posedge core_clk);
			chk1(engOut.tenRestart, d[10] & d[11] & !d[12]);
			chk32({22'h0, engOut.target}, d & 32'h3ff);
			chk1(engOut.tenMode, d[11]);
			chk1(engOut.readDir, d[10]);
			chk32({24'h0, engOut.byteCount}, {24'h0, d[23:16]});
			chk1(engOut.reload, d[24]);
		end
		wr(C1, cfg | 32'h1);
		wr(O1, 32'h54);
		wr(O1, 32'h8054);
		for (int k = 0; k < 8; k++) begin
			v = $urandom & 32'hfe;
			d = 32'h8000 | (32'(k) << 8) | v;
			wr(O2, d & 32'h7ff);
			wr(O2, d);
			wr(O2, 32'h8000 | (32'((k + 1) % 8) << 8) | (v ^ 32'hfe));
			rd(O2, d);
			for (int j = 0; j < 5; j++) begin
				p = (j == 0) ? v[7:1] : (j == 1) ? v[7:1] ^ (7'h1 << k) :
					(j == 2) ? 7'h0 : (j == 3) ? 7'h2a : 7'($urandom);
				e = (k == 7) ? (p[6:3] != 4'h0 && p[6:3] != 4'hf) :
					(((p ^ v[7:1]) >> k) == 7'h0);
				e = e | (p == 7'h2a) | (cfg[19] & (p == 7'h0));
				probe(1'b0, {2'h0, p, 1'b0}, e);
			end
		end
		wr(O2, 32'h0);
		rd(O2, d & 32'h7ff);
		probe(1'b0, 10'h54, 1'b1);
		wr(O1, 32'h0);
		probe(1'b0, 10'h54, 1'b0);
		probe(1'b0, 10'h0, cfg[19]);
		wr(C1, (cfg | 32'h1) ^ 32'h80000);
		probe(1'b0, 10'h0, !cfg[19]);
		wr(O1, 32'h6f5);
		wr(O1, 32'h86f5);
		probe(1'b1, 10'h2f5, 1'b1);
		probe(1'b1, 10'h2f4, 1'b0);
		busy <= 1'b1;
		wr(C2, 32'h01002000);
		repeat (8) @(posedge core_clk);
		chk32(goCnt, 32'h0);
		wr(C2, 32'h02002000);
		repeat (8) @(posedge core_clk);
		chk32(goCnt, 32'h0);
		slow <= 1'b1;
		busy <= 1'b0;
		repeat (12) @(posedge core_clk);
		chk32(goCnt, 32'h1);
		rd(C2, 32'h02000000);
		chk1(engOut.stopReq, 1'b1);
		busy <= 1'b1;
		wr(C2, 32'h2000);
		wr(`IAC_OFF_CLEAR, 32'h8);
		rd(C2, 32'h0);
		busy <= 1'b0;
		repeat (5) @(posedge core_clk);
		chk32(goCnt, 32'h1);
		wr(C2, 32'hc000);
		rd(C2, 32'hc000);
		chk1(engOut.nackNext, 1'b1);
		wr(C1, cfg);
		rd(C2, 32'h0);
		chk1(engOut.stopReq | engOut.nackNext, 1'b0);
		stop_test();
	end
endmodule : iac_ctrl_regs_bench
`default_nettype wire
